// ---- scsd_pkg.sv ----
// scrambler control package: register map, field positions, reset values and delay counts
package scsd_pkg;

    // register offsets on the node processor port
    localparam logic [7:0]  SCSD_CTRL_OFF     = 8'h0A;
    localparam logic [7:0]  SCSD_STAT_OFF     = 8'h10;
    localparam logic [7:0]  SCSD_IRQ_ST_OFF   = 8'h11;
    localparam logic [7:0]  SCSD_IRQ_MASK_OFF = 8'h12;

    // scrambler_control fields
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_LPBK_BIT   = 1;
    localparam int CTRL_OFF_EN_BIT = 6;
    localparam int CTRL_ON_EN_BIT  = 7;
    localparam int CTRL_TXOFF_LSB  = 8;
    localparam int CTRL_ON_LSB     = 10;
    localparam int CTRL_OFF_LSB    = 12;

    // line_state_status fields
    localparam int STAT_SYM_LSB    = 0;
    localparam int STAT_UNKN_BIT   = 3;
    localparam int STAT_LSM_BIT    = 4;
    localparam int STAT_CUR_LSB    = 5;
    localparam int STAT_PRIOR_LSB  = 8;
    localparam int STAT_NOSIG_BIT  = 10;
    localparam int STAT_REV_LSB    = 11;

    // interrupt status and mask fields
    localparam int IRQ_DET_ON_BIT  = 0;
    localparam int IRQ_DET_OFF_BIT = 1;
    localparam int IRQ_TXOFF_BIT   = 2;

    // reset values
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    localparam logic [2:0]  IRQ_MASK_RST = 3'h0;

    // timing, in ns as printed, and the local clock period
    localparam int CLK_PERIOD_NS = 25;
    localparam int DET_OFF_00_NS = 760;
    localparam int DET_ON_00_NS  = 840;
    localparam int DET_01_NS     = 1320;
    localparam int DET_10_NS     = 2520;
    localparam int DET_11_NS     = 5120;
    localparam int TXOFF_01_NS   = 30000;
    localparam int TXOFF_10_NS   = 50000;

    // nearest whole cycle
    function automatic logic [10:0] scsd_ns_to_cyc(input int ns);
        return 11'((ns + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS);
    endfunction

    localparam logic [10:0] DET_OFF_00_CYC = scsd_ns_to_cyc(DET_OFF_00_NS);
    localparam logic [10:0] DET_ON_00_CYC  = scsd_ns_to_cyc(DET_ON_00_NS);
    localparam logic [10:0] DET_01_CYC     = scsd_ns_to_cyc(DET_01_NS);
    localparam logic [10:0] DET_10_CYC     = scsd_ns_to_cyc(DET_10_NS);
    localparam logic [10:0] DET_11_CYC     = scsd_ns_to_cyc(DET_11_NS);
    localparam logic [10:0] TXOFF_01_CYC   = scsd_ns_to_cyc(TXOFF_01_NS);
    localparam logic [10:0] TXOFF_10_CYC   = scsd_ns_to_cyc(TXOFF_10_NS);

    // transmitter-off delay selections
    typedef enum logic [1:0] {
        TXOFF_NOW   = 2'b00,
        TXOFF_30US  = 2'b01,
        TXOFF_50US  = 2'b10,
        TXOFF_NEVER = 2'b11
    } scsd_txoff_t;

endpackage

// ---- scsd_delay_timer.sv ----
// delay counter: counts while run is high, expired once the limit is reached
`timescale 1ns/1ps
module scsd_delay_timer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        run,
    input  wire logic [10:0] limit,
    output logic             expired
);

    typedef struct packed {
        logic [10:0] cnt;
    } scsd_tmr_t;

    scsd_tmr_t tmr_q;
    scsd_tmr_t tmr_d;

    // >= so a limit lowered mid-count still ends the wait
    assign expired = run && (tmr_q.cnt >= limit);

    always_comb begin
        tmr_d = tmr_q;
        if (!run) begin
            tmr_d.cnt = 11'h000;
        end else if (tmr_q.cnt < limit) begin
            tmr_d.cnt = tmr_q.cnt + 11'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tmr_q <= '0;
        end else if (ce) begin
            tmr_q <= tmr_d;
        end
    end

endmodule

// ---- scsd_ctrl.sv ----
// scrambler control, signal-detect delay, transmitter-off delay and status registers
//
// Summary of operation
// - reset clears control bits 15 down to 1.
// - after reset bit 0 reads as the scrambler strap level.
// - control register sits at offset 0A, readable and writable.
// - off-delay field picks 0.76, 1.32, 2.52 or 5.12 us.
// - on-delay field picks 0.84, 1.32, 2.52 or 5.12 us.
// - on-delay enable with scrambling delays signal-detect rising.
// - off-delay enable with scrambling delays signal-detect falling.
// - transmitter-off field 01 waits 30 us, 10 waits 50 us.
// - field 00 raises transmitter-off at once; 11 never raises it.
// - loopback bit routes scrambler output into the descrambler.
// - strap low: software bit 0 enables scrambling, default 0.
// - strap high: scrambler enable held at one.
// - status register at offset 10 is read-only.
// - status bit 10 is the inverse of the signal-present pin.
// - status bits 15 to 11 hold a fixed revision code.
`timescale 1ns/1ps
module scsd_ctrl
    import scsd_pkg::*;
#(
    parameter logic [4:0] SILICON_REV_CODE = 5'h0A  // value is arbitrary
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic [7:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic        SCRAMBLER_STRAP_PIN,
    input  wire logic        SIGNAL_PRESENT_INPUT,
    input  wire logic        TX_QUIET_SCRAMBLED,
    input  wire logic [2:0]  CURRENT_LINE_STATE,
    input  wire logic [1:0]  PRIOR_LINE_STATE,
    input  wire logic        LINE_STATE_MACHINE_STATE,
    input  wire logic        UNKNOWN_LINE_STATE,
    input  wire logic [2:0]  SYMBOL_PAIR_COUNT,
    output logic             SCRAMBLER_EN,
    output logic             SCRAMBLER_LOOPBACK,
    output logic             SIGNAL_DETECT,
    output logic             OPTICAL_TX_OFF,
    output logic             IRQ
);

    typedef struct packed {
        logic [15:0] ctrl;
        logic        strap_m;
        logic        strap_s;
        logic        sd_m;
        logic        sd_s;
        logic        det;
        logic        tx_off;
        logic [2:0]  irq_st;
        logic [2:0]  irq_mask;
        logic [15:0] rdata;
        logic [11:0] mis_cnt;
        logic [11:0] quiet_cnt;
    } scsd_state_t;

    localparam scsd_state_t ST_RST = '{
        ctrl:     CTRL_RST,
        irq_mask: IRQ_MASK_RST,
        default:  '0
    };

    scsd_state_t st_q;
    scsd_state_t st_d;

    logic        scr_en;
    logic [15:0] ctrl_rd;
    logic [15:0] stat_rd;
    logic [1:0]  off_sel;
    logic [1:0]  on_sel;
    logic [1:0]  tx_sel;
    logic        on_en;
    logic        off_en;
    logic        quiet_scr;
    logic [10:0] off_lim;
    logic [10:0] on_lim;
    logic [10:0] sd_limit;
    logic [10:0] tx_limit;
    logic        sd_run;
    logic        sd_expired;
    logic        tx_expired;
    logic        wr_ctrl;
    logic        wr_irq;
    logic        wr_mask;
    logic [2:0]  irq_ev;

    assign off_sel = st_q.ctrl[CTRL_OFF_LSB +: 2];
    assign on_sel  = st_q.ctrl[CTRL_ON_LSB +: 2];
    assign tx_sel  = st_q.ctrl[CTRL_TXOFF_LSB +: 2];
    assign on_en   = st_q.ctrl[CTRL_ON_EN_BIT];
    assign off_en  = st_q.ctrl[CTRL_OFF_EN_BIT];

    // strap overrides the stored bit without changing it
    assign scr_en = st_q.ctrl[CTRL_EN_BIT] | st_q.strap_s;

    // bit 0 reads the effective enable, so it follows the strap after reset
    always_comb begin
        ctrl_rd = st_q.ctrl;
        ctrl_rd[CTRL_EN_BIT] = scr_en;
    end

    // status is assembled live from the line state machine inputs
    always_comb begin
        stat_rd = 16'h0000;
        stat_rd[STAT_REV_LSB +: 5] = SILICON_REV_CODE;
        stat_rd[STAT_NOSIG_BIT] = ~st_q.sd_s;
        stat_rd[STAT_PRIOR_LSB +: 2] = PRIOR_LINE_STATE;
        stat_rd[STAT_CUR_LSB +: 3] = CURRENT_LINE_STATE;
        stat_rd[STAT_LSM_BIT] = LINE_STATE_MACHINE_STATE;
        stat_rd[STAT_UNKN_BIT] = UNKNOWN_LINE_STATE;
        stat_rd[STAT_SYM_LSB +: 3] = SYMBOL_PAIR_COUNT;
    end

    // delay tables, each entry rounded to the nearest clock
    always_comb begin
        case (off_sel)
            2'b00:   off_lim = DET_OFF_00_CYC;
            2'b01:   off_lim = DET_01_CYC;
            2'b10:   off_lim = DET_10_CYC;
            default: off_lim = DET_11_CYC;
        endcase
        case (on_sel)
            2'b00:   on_lim = DET_ON_00_CYC;
            2'b01:   on_lim = DET_01_CYC;
            2'b10:   on_lim = DET_10_CYC;
            default: on_lim = DET_11_CYC;
        endcase
        case (tx_sel)
            TXOFF_30US: tx_limit = TXOFF_01_CYC;
            TXOFF_50US: tx_limit = TXOFF_10_CYC;
            default:    tx_limit = 11'h000;
        endcase
    end

    // without scrambling or with the delay disabled the detect follows at once
    always_comb begin
        sd_limit = 11'h000;
        if (scr_en && st_q.sd_s && on_en) begin
            sd_limit = on_lim;
        end else if (scr_en && !st_q.sd_s && off_en) begin
            sd_limit = off_lim;
        end
    end

    // a pin glitch shorter than the delay restarts the wait
    assign sd_run = st_q.sd_s != st_q.det;

    scsd_delay_timer u_det_timer (
        .clk     (CLK),
        .rst     (RST),
        .ce      (CE),
        .run     (sd_run),
        .limit   (sd_limit),
        .expired (sd_expired)
    );

    assign quiet_scr = TX_QUIET_SCRAMBLED & scr_en;

    scsd_delay_timer u_tx_timer (
        .clk     (CLK),
        .rst     (RST),
        .ce      (CE),
        .run     (quiet_scr),
        .limit   (tx_limit),
        .expired (tx_expired)
    );

    // register port decode
    always_comb begin
        wr_ctrl = 1'b0;
        wr_irq  = 1'b0;
        wr_mask = 1'b0;
        if (WR && ADDR == SCSD_CTRL_OFF) begin
            wr_ctrl = 1'b1;
        end else if (WR && ADDR == SCSD_IRQ_ST_OFF) begin
            wr_irq = 1'b1;
        end else if (WR && ADDR == SCSD_IRQ_MASK_OFF) begin
            wr_mask = 1'b1;
        end
    end

    always_comb begin
        st_d = st_q;
        // two-stage synchronisers on the pins
        st_d.strap_m = SCRAMBLER_STRAP_PIN;
        st_d.strap_s = st_q.strap_m;
        st_d.sd_m    = SIGNAL_PRESENT_INPUT;
        st_d.sd_s    = st_q.sd_m;

        // reserved and diagnostic bits are stored as written
        if (wr_ctrl) begin
            st_d.ctrl = WDATA;
        end

        if (sd_expired) begin
            st_d.det = st_q.sd_s;
        end

        st_d.tx_off = quiet_scr && tx_sel != TXOFF_NEVER && tx_expired;

        irq_ev = 3'h0;
        irq_ev[IRQ_DET_ON_BIT]  = sd_expired && st_q.sd_s && !st_q.det;
        irq_ev[IRQ_DET_OFF_BIT] = sd_expired && !st_q.sd_s && st_q.det;
        irq_ev[IRQ_TXOFF_BIT]   = st_d.tx_off && !st_q.tx_off;
        // a new event wins over a clear in the same cycle
        if (wr_irq) begin
            st_d.irq_st = (st_q.irq_st & ~WDATA[2:0]) | irq_ev;
        end else begin
            st_d.irq_st = st_q.irq_st | irq_ev;
        end
        if (wr_mask) begin
            st_d.irq_mask = WDATA[2:0];
        end

        // read data stands only in the cycle after the strobe
        st_d.rdata = 16'h0000;
        if (RD) begin
            if (ADDR == SCSD_CTRL_OFF) begin
                st_d.rdata = ctrl_rd;
            end else if (ADDR == SCSD_STAT_OFF) begin
                st_d.rdata = stat_rd;
            end else if (ADDR == SCSD_IRQ_ST_OFF) begin
                st_d.rdata = {13'h0000, st_q.irq_st};
            end else if (ADDR == SCSD_IRQ_MASK_OFF) begin
                st_d.rdata = {13'h0000, st_q.irq_mask};
            end
        end

        // cycle counters watched by the checks below
        if (!sd_run) begin
            st_d.mis_cnt = 12'h000;
        end else if (st_q.mis_cnt != 12'hFFF) begin
            st_d.mis_cnt = st_q.mis_cnt + 12'h001;
        end
        if (!quiet_scr) begin
            st_d.quiet_cnt = 12'h000;
        end else if (st_q.quiet_cnt != 12'hFFF) begin
            st_d.quiet_cnt = st_q.quiet_cnt + 12'h001;
        end
    end

    // reset dominates the clock enable so the strap is sampled cleanly
    always_ff @(posedge CLK) begin
        if (RST) begin
            st_q <= ST_RST;
        end else if (CE) begin
            st_q <= st_d;
        end
    end

    assign RDATA              = st_q.rdata;
    assign SCRAMBLER_EN       = scr_en;
    assign SCRAMBLER_LOOPBACK = st_q.ctrl[CTRL_LPBK_BIT];
    assign SIGNAL_DETECT      = st_q.det;
    assign OPTICAL_TX_OFF     = st_q.tx_off;
    assign IRQ                = |(st_q.irq_st & st_q.irq_mask);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    ctrl_reset_a: assert property (
        $fell(RST) |-> st_q.ctrl[15:1] == 15'h0000
    ) else $error("control bits 15..1 not cleared by reset");

    strap_load_a: assert property (
        $fell(RST) |-> ctrl_rd[CTRL_EN_BIT] == st_q.strap_s
    ) else $error("enable bit does not follow strap after reset");

    ctrl_read_a: assert property (
        RD && ADDR == SCSD_CTRL_OFF && CE |=> RDATA == $past(ctrl_rd)
    ) else $error("control register read back wrong");

    off_time_a: assert property (
        scr_en && off_en && !st_q.sd_s && off_sel == 2'b11 |-> sd_limit == 11'h0CD
    ) else $error("off delay 11 is not 205 cycles");

    on_time_a: assert property (
        scr_en && on_en && st_q.sd_s && on_sel == 2'b01 |-> sd_limit == 11'h035
    ) else $error("on delay 01 is not 53 cycles");

    // a limit lowered mid-wait ends it at once, so early and late are checked apart
    detect_wait_a: assert property (
        $changed(st_q.det) |-> $past(st_q.mis_cnt) >= {1'b0, $past(sd_limit)}
    ) else $error("signal detect changed before its wait ran out");

    detect_late_a: assert property (
        sd_run && st_q.mis_cnt >= {1'b0, sd_limit} && CE |=> st_q.det == $past(st_q.sd_s)
    ) else $error("signal detect held past its wait");

    detect_direct_a: assert property (
        !scr_en && sd_run && CE |=> st_q.det == $past(st_q.sd_s)
    ) else $error("signal detect delayed while scrambling is off");

    tx_delay_a: assert property (
        $rose(OPTICAL_TX_OFF) && $past(tx_sel) == TXOFF_30US
            |-> $past(st_q.quiet_cnt) >= 12'h4B0
    ) else $error("transmitter off raised before 30 us");

    tx_never_a: assert property (
        tx_sel == TXOFF_NEVER && $past(tx_sel) == TXOFF_NEVER |-> !OPTICAL_TX_OFF
    ) else $error("transmitter off raised with field 11");

    loopback_a: assert property (
        wr_ctrl && CE |=> SCRAMBLER_LOOPBACK == $past(WDATA[CTRL_LPBK_BIT])
    ) else $error("loopback bit does not take the written value");

    strap_force_a: assert property (
        st_q.strap_s |-> SCRAMBLER_EN
    ) else $error("scrambler off while strap asserted");

    status_inv_a: assert property (
        RD && ADDR == SCSD_STAT_OFF && CE |=> RDATA[STAT_NOSIG_BIT] == !$past(st_q.sd_s)
    ) else $error("status bit 10 is not the inverted detect pin");

    rev_code_a: assert property (
        RD && ADDR == SCSD_STAT_OFF && CE |=> RDATA[STAT_REV_LSB +: 5] == SILICON_REV_CODE
    ) else $error("revision code field read back wrong");

    stat_ro_a: assert property (
        WR && ADDR == SCSD_STAT_OFF && CE
            |=> st_q.ctrl == $past(st_q.ctrl) && st_q.irq_mask == $past(st_q.irq_mask)
    ) else $error("write to the status offset changed a register");

    rdata_idle_a: assert property (
        !RD && CE |=> RDATA == 16'h0000
    ) else $error("read data stands without a read strobe");

    tx_now_a: assert property (
        quiet_scr && tx_sel == TXOFF_NOW && CE |=> OPTICAL_TX_OFF
    ) else $error("transmitter off late with field 00");

    tx_late_a: assert property (
        $rose(OPTICAL_TX_OFF) && $past(tx_sel) == TXOFF_50US
            |-> $past(st_q.quiet_cnt) >= 12'h7D0
    ) else $error("transmitter off raised before 50 us");

    // the clock enable must hold every register of st_q, the cycle counters included
    ce_freeze_a: assert property (
        !CE |=> st_q == $past(st_q)
    ) else $error("state moved while the clock enable was low");

endmodule

// ---- scsd_media_model.sv ----
// media-side model: receiver signal-present level and transmit quiet indication
`timescale 1ns/1ps
module scsd_media_model (
    input  wire logic light_req,
    input  wire logic quiet_req,
    output logic      signal_present,
    output logic      tx_quiet
);
    // receiver output is not tied to the local clock, so it lands mid-cycle
    assign #3 signal_present = light_req;
    assign tx_quiet = quiet_req;
endmodule

// ---- scsd_ctrl_test.sv ----
// self-checking testbench for the scrambler control block
`timescale 1ns/1ps
module scsd_ctrl_test;
    import scsd_pkg::*;
    localparam logic [4:0] REV = 5'h15;  // value is arbitrary
    logic        clk, rst, ce, rd, wr, strap, light, quiet, pres, txq;
    logic        en, lpbk, sdet, txoff, irq, line_state_machine, unkn;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, d, q;
    logic [2:0]  cur, sym;
    logic [1:0]  prior;
    int          n_fail, checks;

    scsd_media_model u_scsd_media_model (.light_req(light), .quiet_req(quiet),
        .signal_present(pres), .tx_quiet(txq));
    scsd_ctrl #(.SILICON_REV_CODE(REV)) u_scsd_ctrl (.CLK(clk), .RST(rst), .CE(ce),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .SCRAMBLER_STRAP_PIN(strap), .SIGNAL_PRESENT_INPUT(pres), .TX_QUIET_SCRAMBLED(txq),
        .CURRENT_LINE_STATE(cur), .PRIOR_LINE_STATE(prior), .LINE_STATE_MACHINE_STATE(line_state_machine),
        .UNKNOWN_LINE_STATE(unkn), .SYMBOL_PAIR_COUNT(sym), .SCRAMBLER_EN(en),
        .SCRAMBLER_LOOPBACK(lpbk), .SIGNAL_DETECT(sdet), .OPTICAL_TX_OFF(txoff), .IRQ(irq));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
    endtask

    // nearest whole cycle of a time in ns, plus the two synchroniser stages and output flop
    function automatic int exp_det(input logic [15:0] c, input logic v);
        int t_on[4];
        int t_off[4];
        t_on  = '{840, 1320, 2520, 5120};
        t_off = '{760, 1320, 2520, 5120};
        if (!c[0]) return 3;
        if (v && c[7]) return (t_on[c[11:10]] * 2 + 25) / 50 + 3;
        if (!v && c[6]) return (t_off[c[13:12]] * 2 + 25) / 50 + 3;
        return 3;
    endfunction

    task automatic det(input logic [15:0] c, input logic v);
        int n;
        wr_reg(SCSD_CTRL_OFF, c);
        @(posedge clk);
        light <= v;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            #1;
        end while (sdet !== v && n < 300);
        chk(16'(n), 16'(exp_det(c, v)));
    endtask

    task automatic txo(input logic [1:0] s);
        int n;
        int e;
        e = (s == 2'b00) ? 1 : (s == 2'b01) ? 30000 / 25 + 1 : (s == 2'b10) ? 50000 / 25 + 1 : 0;
        wr_reg(SCSD_CTRL_OFF, {6'h00, s, 8'h01});
        @(posedge clk);
        quiet <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            #1;
        end while (txoff !== 1'b1 && n < 2100);
        chk(16'(txoff === 1'b1 ? n : 0), 16'(e));
        @(posedge clk);
        quiet <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({15'h0, txoff}, 16'h0000);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        {rst, rd, wr, strap, light, quiet, line_state_machine, unkn} = 8'h80;
        {addr, wdata, cur, sym, prior} = '0;
        ce = 1'b1;
        n_fail = 0;
        checks = 0;
        void'($urandom(32'h7176));
        do_reset();
        rd_reg(SCSD_CTRL_OFF, d);
        chk(d, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            d = 16'($urandom) & 16'h3FC3;  // diagnostic bits kept clear
            if (i == 0) d[5:2] = 4'hF;  // reserved bits written anyway
            wr_reg(SCSD_CTRL_OFF, d);
            rd_reg(SCSD_CTRL_OFF, q);
            chk(q, d);
            chk({14'h0, lpbk, en}, {14'h0, d[1:0]});
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {cur, prior, line_state_machine, unkn, sym} <= 10'($urandom);
            light <= 1'(i);
            repeat (4) @(posedge clk);
            wr_reg(SCSD_STAT_OFF, 16'hFFFF);
            rd_reg(SCSD_STAT_OFF, d);
            chk(d, {REV, ~light, prior, cur, line_state_machine, unkn, sym});
        end
        rd_reg(8'h2F, d);
        chk(d, 16'h0000);
        $display("test register map done");
        @(posedge clk);
        strap <= 1'b1;
        repeat (4) @(posedge clk);
        wr_reg(SCSD_CTRL_OFF, 16'h0000);
        rd_reg(SCSD_CTRL_OFF, d);
        chk({14'h0, d[0], en}, 16'h0003);
        do_reset();
        repeat (3) @(posedge clk);
        rd_reg(SCSD_CTRL_OFF, d);
        chk(d, 16'h0001);
        @(posedge clk);
        strap <= 1'b0;
        repeat (4) @(posedge clk);
        rd_reg(SCSD_CTRL_OFF, d);
        chk({15'h0, d[0]}, 16'h0000);
        // a write while the clock enable is low must not land
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(SCSD_CTRL_OFF, 16'h0002);
        @(posedge clk);
        ce <= 1'b1;
        rd_reg(SCSD_CTRL_OFF, d);
        chk(d, 16'h0000);
        chk({15'h0, lpbk}, 16'h0000);
        $display("test strap done");
        @(posedge clk);
        light <= 1'b0;
        repeat (4) @(posedge clk);
        wr_reg(SCSD_IRQ_ST_OFF, 16'h0007);
        rd_reg(SCSD_IRQ_ST_OFF, d);
        chk(d, 16'h0000);
        wr_reg(SCSD_IRQ_MASK_OFF, 16'h0001);
        det(16'h00C0, 1'b1);
        chk({15'h0, irq}, 16'h0001);
        wr_reg(SCSD_IRQ_ST_OFF, 16'h0001);
        @(posedge clk);
        #1 chk({15'h0, irq}, 16'h0000);
        det(16'h00C0, 1'b0);
        chk({15'h0, irq}, 16'h0000);
        rd_reg(SCSD_IRQ_ST_OFF, d);
        chk(d, 16'h0002);
        $display("test interrupt done");
        for (int s = 0; s < 4; s++) begin
            d = {2'b00, 2'(s), 2'(3 - s), 2'(s), 2'b11, 6'h01};
            det(d, 1'b1);
            det(d, 1'b0);
            det(d & 16'hFFBF, 1'b1);
            det(d & 16'hFF7F, 1'b0);
        end
        $display("test signal detect done");
        for (int s = 0; s < 4; s++)
            txo(2'(s));
        $display("test transmitter off done");
        print_verdict();
    end
endmodule
